// file: inc/tfm_pkg.sv
// Package: constants for the time-of-flight measure block
// How it works
// [R1] Counter starts on window rising edge
// [R2] Signal edge captures period, clears counter
// [R3] Two window edges capture width, clear
// [R4] Counter low byte readable, writable, resets zero
// [R5] Counter 24 bits, upper byte separately accessible
// [R6] Sources give clean levels, synchronised here
package tfm_pkg;
	// Counter width
	localparam int CNT_W = 24;
	// Register byte addresses, one aligned word each
	localparam logic [7:0] ADDR_CNT_LOW = 8'h00;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'h04;
	localparam logic [7:0] ADDR_CNT_UPPER = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0C;
	localparam logic [7:0] ADDR_WIDTH = 8'h10;
	localparam logic [7:0] ADDR_CTRL = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Control field positions
	localparam int CTRL_EN_BIT = 0;
	// Status field positions
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_PER_BIT = 1;
	localparam int STAT_WID_BIT = 2;
	// Reset values
	localparam logic [23:0] CNT_RESET = 24'h000000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : tfm_pkg

// file: sim/tfm_src.sv
// Window and measured signal source model
`timescale 1ns/1ps
module tfm_src (
	input logic sys_clk,
	input logic go_win,
	input logic go_sig,
	output logic window_input,
	output logic measured_signal_input
);
	// Clean six clock pulses, long enough to pass the synchroniser
	logic [2:0] w_ff = 3'h0, s_ff = 3'h0;
	always @(posedge sys_clk) begin
		w_ff <= go_win ? 3'h6 : w_ff - 3'(|w_ff);
		s_ff <= go_sig ? 3'h6 : s_ff - 3'(|s_ff);
	end
	assign window_input = |w_ff;
	assign measured_signal_input = |s_ff;
endmodule : tfm_src

// file: sim/tfm_top_assertions.sv
// Port checker for the time-of-flight block
`timescale 1ns/1ps
module tfm_top_assertions (
	input logic sys_clk,
	input logic rst_n,
	input logic window_input,
	input logic measured_signal_input,
	input logic avs_read,
	input logic avs_write,
	input logic avs_waitrequest,
	input logic running,
	input logic [23:0] period_capture_reg,
	input logic [23:0] pulse_width_capture_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Fresh request; bench idles one cycle between
	sequence req_s;
		$rose(avs_read || avs_write);
	endsequence
	arm_start_a: assert property ($rose(running) |-> $past(window_input, 2))
		else $error("arm without window");
	period_cap_a: assert property ($changed(period_capture_reg) |-> $past(measured_signal_input, 2))
		else $error("period without edge");
	width_cap_a: assert property ($changed(pulse_width_capture_reg) |-> $past(window_input, 2))
		else $error("width without window");
	bus_answer_a: assert property (req_s |=> !avs_waitrequest)
		else $error("late bus answer");
	ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
endmodule : tfm_top_assertions
bind tfm_top tfm_top_assertions chk (.sys_clk(sys_clk), .rst_n(rst_n), .window_input(window_input),
	.measured_signal_input(measured_signal_input), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .running(running), .period_capture_reg(period_capture_reg),
	.pulse_width_capture_reg(pulse_width_capture_reg));

// file: sim/tfm_top_test.sv
// Self-checking bench for the time-of-flight block
`timescale 1ns/1ps
module tfm_top_test;
	logic sys_clk = 1'b0, rst_n = 1'b0, gw = 1'b0, gs = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0, rdat;
	logic win, sig, wt, running;
	logic [23:0] per, wid, p1;
	int bad_count = 0, checks_done = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	tfm_src src (.sys_clk(sys_clk), .go_win(gw), .go_sig(gs), .window_input(win), .measured_signal_input(sig));
	tfm_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .window_input(win), .measured_signal_input(sig),
		.avs_address(ad), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdat), .avs_waitrequest(wt), .running(running), .period_capture_reg(per),
		.pulse_width_capture_reg(wid));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Held until waitrequest low; a read compares against d
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		ad <= a;
		wd <= d;
		do @(posedge sys_clk); while (wt !== 1'b0);
		if (!w) chk("readdata", rdat, d);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	// One source pulse, then a gap in clocks
	task fire(input logic w, input int gap);
		gw <= w;
		gs <= !w;
		@(posedge sys_clk);
		gw <= 1'b0;
		gs <= 1'b0;
		repeat (gap - 1) @(posedge sys_clk);
	endtask : fire
	task t_regs;
		bus(0, tfm_pkg::ADDR_CNT_LOW, 32'h0);
		bus(1, tfm_pkg::ADDR_CNT_LOW, 32'hA5);
		bus(0, tfm_pkg::ADDR_CNT_LOW, 32'hA5);
		bus(1, tfm_pkg::ADDR_CNT_UPPER, 32'h3C);
		bus(0, tfm_pkg::ADDR_CNT_UPPER, 32'h3C);
		bus(0, 8'h40, 32'h0);
	endtask : t_regs
	// Edge spacings 20 then 40 must differ by 20 counts
	task t_period;
		bus(1, tfm_pkg::ADDR_CTRL, 32'h1);
		fire(1, 10);
		chk("running", running, 1);
		fire(0, 20);
		fire(0, 40);
		p1 = per;
		fire(0, 10);
		chk("period", per - p1, 32'h14);
	endtask : t_period
	// First window edge only clears the signal-seen mark; width starts after the second
	task t_width;
		fire(1, 20);
		fire(1, 20);
		fire(1, 40);
		p1 = wid;
		fire(1, 10);
		chk("width", wid - p1, 32'h14);
		bus(0, tfm_pkg::ADDR_WIDTH, 32'h27);
		bus(0, tfm_pkg::ADDR_PERIOD, 32'h27);
		bus(0, tfm_pkg::ADDR_STATUS, 32'h7);
		bus(1, tfm_pkg::ADDR_STATUS, 32'h6);
		bus(0, tfm_pkg::ADDR_STATUS, 32'h1);
		bus(0, tfm_pkg::ADDR_CTRL, 32'h1);
	endtask : t_width
	task test_done;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_period();
		t_width();
		test_done();
	end
endmodule : tfm_top_test

// file: src/tfm_edge.sv
// Synchroniser with rising edge detector for one input
`timescale 1ns/1ps
module tfm_edge (
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	input wire logic din,
	output logic rise
);
	// Two sync stages plus one history stage
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} tfm_edge_t;
	tfm_edge_t st_ff;
	tfm_edge_t nxt_st;

	// First stage feeds only the second
	always_comb begin
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Rising edge seen on synchronised level
	assign rise = st_ff.s2 & ~st_ff.s3; // [R6]
endmodule : tfm_edge

// file: src/tfm_top.sv
// Time-of-flight measurement timer with Avalon-MM register slave
`timescale 1ns/1ps
module tfm_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic window_input,
	input wire logic measured_signal_input,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic running,
	output logic [23:0] period_capture_reg,
	output logic [23:0] pulse_width_capture_reg
);
	// Whole block state
	typedef struct packed {
		logic [23:0] cnt;      // Measurement counter
		logic [23:0] per;      // Period capture
		logic [23:0] wid;      // Pulse width capture
		logic run;             // Counting armed
		logic sig_seen;        // Signal edge since last window edge
		logic en;              // Software enable
		logic per_new;         // Period captured, sticky
		logic wid_new;         // Width captured, sticky
		logic [31:0] rdata;    // Read data
		logic ack;             // Access answered this cycle
	} tfm_state_t;
	tfm_state_t st_ff;
	tfm_state_t nxt_st;

	// Reset release copy
	logic [1:0] rst_sync_ff;
	logic rst_sync_n;
	logic win_rise;
	logic sig_rise;
	logic req;
	logic wr_hit;
	logic [31:0] wmask;

	// Reset released through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_ff[1];

	// Edge detectors on both external inputs
	tfm_edge u_win (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.din(window_input),
		.rise(win_rise)
	);
	tfm_edge u_sig (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.din(measured_signal_input),
		.rise(sig_rise)
	);

	// Access takes one wait cycle, answered when ack is set
	assign req = (avs_read | avs_write) & ~st_ff.ack;
	assign wr_hit = avs_write & ~st_ff.ack;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Measurement and register logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = req;
		// Measurement sequence, only while enabled
		if (!st_ff.en) begin
			nxt_st.run = 1'b0;
			nxt_st.sig_seen = 1'b0;
		end else begin
			if (st_ff.run) begin
				nxt_st.cnt = st_ff.cnt + 24'h000001; // [R1]
			end
			if (win_rise) begin
				if (st_ff.run && !st_ff.sig_seen) begin
					// Second window edge without signal edge
					nxt_st.wid = st_ff.cnt; // [R3]
					nxt_st.cnt = tfm_pkg::CNT_RESET; // [R3]
					nxt_st.wid_new = 1'b1;
				end else if (!st_ff.run) begin
					nxt_st.cnt = tfm_pkg::CNT_RESET;
				end
				nxt_st.run = 1'b1; // [R1]
				nxt_st.sig_seen = 1'b0;
			end
			// On a tie the period is still captured, and the window edge starts a new interval
			if (sig_rise && st_ff.run) begin
				nxt_st.per = st_ff.cnt; // [R2]
				nxt_st.cnt = tfm_pkg::CNT_RESET; // [R2]
				nxt_st.per_new = 1'b1;
				nxt_st.sig_seen = !win_rise;
			end
		end
		// Register writes, byte lanes honoured; software write beats count
		if (wr_hit) begin
			case (avs_address)
				tfm_pkg::ADDR_CNT_LOW: begin
					if (avs_byteenable[0]) nxt_st.cnt[7:0] = avs_writedata[7:0]; // [R4]
				end
				tfm_pkg::ADDR_CNT_HIGH: begin
					if (avs_byteenable[0]) nxt_st.cnt[15:8] = avs_writedata[7:0];
				end
				tfm_pkg::ADDR_CNT_UPPER: begin
					if (avs_byteenable[0]) nxt_st.cnt[23:16] = avs_writedata[7:0]; // [R5]
				end
				tfm_pkg::ADDR_CTRL: begin
					if (avs_byteenable[0]) nxt_st.en = avs_writedata[tfm_pkg::CTRL_EN_BIT];
				end
				tfm_pkg::ADDR_STATUS: begin
					// Write one to clear; a new capture in same cycle wins
					if (avs_byteenable[0] && avs_writedata[tfm_pkg::STAT_PER_BIT] && !(sig_rise && st_ff.run && st_ff.en))
						nxt_st.per_new = 1'b0;
					// Same set-wins rule as the period flag, even when the flag is already set
					if (avs_byteenable[0] && avs_writedata[tfm_pkg::STAT_WID_BIT]
						&& !(win_rise && st_ff.run && !st_ff.sig_seen && st_ff.en))
						nxt_st.wid_new = 1'b0;
				end
				default: begin
					// Unmapped write ignored
				end
			endcase
		end
		// Read data, captured for the answer cycle
		nxt_st.rdata = tfm_pkg::UNMAPPED_READ;
		if (avs_read && !st_ff.ack) begin
			case (avs_address)
				tfm_pkg::ADDR_CNT_LOW: nxt_st.rdata = {24'h000000, st_ff.cnt[7:0]}; // [R4]
				tfm_pkg::ADDR_CNT_HIGH: nxt_st.rdata = {24'h000000, st_ff.cnt[15:8]};
				tfm_pkg::ADDR_CNT_UPPER: nxt_st.rdata = {24'h000000, st_ff.cnt[23:16]}; // [R5]
				tfm_pkg::ADDR_PERIOD: nxt_st.rdata = {8'h00, st_ff.per};
				tfm_pkg::ADDR_WIDTH: nxt_st.rdata = {8'h00, st_ff.wid};
				tfm_pkg::ADDR_CTRL: nxt_st.rdata = {31'h00000000, st_ff.en};
				tfm_pkg::ADDR_STATUS: nxt_st.rdata = {29'h00000000, st_ff.wid_new, st_ff.per_new, st_ff.run};
				default: nxt_st.rdata = tfm_pkg::UNMAPPED_READ;
			endcase
			nxt_st.rdata = nxt_st.rdata & wmask;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flops
	assign avs_readdata = st_ff.rdata;
	assign avs_waitrequest = ~st_ff.ack;
	assign running = st_ff.run;
	assign period_capture_reg = st_ff.per;
	assign pulse_width_capture_reg = st_ff.wid;
endmodule : tfm_top
